// >>> fre_axil.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the owner decodes wr_go and rd_go in the cycle they are high.
`timescale 1ns/1ps
`default_nettype none
module fre_axil (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [fre_pkg::BUS_AB-1:0] awaddr,
	input  wire logic                       wvalid,
	output logic                            wready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	output logic                            bvalid,
	input  wire logic                       bready,
	output logic      [1:0]                 bresp,
	input  wire logic                       arvalid,
	output logic                            arready,
	input  wire logic [fre_pkg::BUS_AB-1:0] araddr,
	output logic                            rvalid,
	input  wire logic                       rready,
	output logic      [31:0]                rdata,
	output logic      [1:0]                 rresp,
	output logic                            wr_go,
	output logic      [fre_pkg::BUS_AB-1:0] wr_a,
	output logic      [31:0]                wr_d,
	output logic      [3:0]                 wr_s,
	input  wire logic                       wr_err,
	output logic                            rd_go,
	output logic      [fre_pkg::BUS_AB-1:0] rd_a,
	input  wire logic [31:0]                rd_d,
	input  wire logic                       rd_err
);
	import fre_pkg::*;

	typedef struct packed {
		logic              awr, wr, ar;
		logic              aw_h, w_h, go, bv;
		logic [1:0]        br;
		logic [BUS_AB-1:0] wa;
		logic [31:0]       wd;
		logic [3:0]        ws;
		logic              rg, rv;
		logic [BUS_AB-1:0] ra;
		logic [31:0]       rd;
		logic [1:0]        rr;
	} fre_axil_s;

	fre_axil_s q;
	fre_axil_s d;

	always_comb begin
		d = q;
		d.go = 1'b0;
		d.rg = 1'b0;
		if (awvalid && q.awr) begin
			d.aw_h = 1'b1;
			d.wa = awaddr;
			d.awr = 1'b0;
		end
		if (wvalid && q.wr) begin
			d.w_h = 1'b1;
			d.wd = wdata;
			d.ws = wstrb;
			d.wr = 1'b0;
		end
		if (q.aw_h && q.w_h) begin
			d.go = 1'b1;
			d.aw_h = 1'b0;
			d.w_h = 1'b0;
		end
		if (q.go) begin
			d.bv = 1'b1;
			d.br = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		// Channels reopen only after the response is taken
		if (q.bv && bready) begin
			d.bv = 1'b0;
			d.awr = 1'b1;
			d.wr = 1'b1;
		end
		if (arvalid && q.ar) begin
			d.ar = 1'b0;
			d.rg = 1'b1;
			d.ra = araddr;
		end
		if (q.rg) begin
			d.rv = 1'b1;
			d.rd = rd_d;
			d.rr = rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (q.rv && rready) begin
			d.rv = 1'b0;
			d.ar = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.awr <= 1'b1;
			q.wr <= 1'b1;
			q.ar <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign awready = q.awr;
	assign wready  = q.wr;
	assign bvalid  = q.bv;
	assign bresp   = q.br;
	assign arready = q.ar;
	assign rvalid  = q.rv;
	assign rdata   = q.rd;
	assign rresp   = q.rr;
	assign wr_go   = q.go;
	assign wr_a    = q.wa;
	assign wr_d    = q.wd;
	assign wr_s    = q.ws;
	assign rd_go   = q.rg;
	assign rd_a    = q.ra;
endmodule // fre_axil
`default_nettype wire

// >>> fre_fault_encoder.sv
// DMA remapping fault reason encoder: classifies each walk outcome.
// Assumes the translation walker runs on aclk and gives one-cycle
// results; software reaches the registers over AXI4-Lite.
// Limitation: interrupt remapping faults are not classified here.
// The fault output never waits for recording, which trails by one.
//
// Summary of operation
// - Code zero never reported for a fault.
// - Root entry not present gives code 1.
// - Context entry not present gives code 2.
// - Invalid context programming gives code 3.
// - Address beyond guest width gives code 4.
// - Write through non-writable entry gives 5.
// - Read through non-readable entry gives 6.
// - Zero-length read capability skips write-only read fault.
// - Next-level table fetch error gives 7.
// - Root table fetch error gives 8.
// - Context table fetch error gives 9.
// - Present root entry reserved bits give A.
// - Present context entry reserved bits give B.
// - Permitted table entry reserved bits give C.
// - Translation type block gives code D.
`timescale 1ns/1ps
`default_nettype none
module fre_fault_encoder (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// Register bus
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [fre_pkg::BUS_AB-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic      [1:0]                 s_axi_bresp,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [fre_pkg::BUS_AB-1:0] s_axi_araddr,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic      [31:0]                s_axi_rdata,
	output logic      [1:0]                 s_axi_rresp,
	// Walker result, one cycle per request
	input  wire logic                       wk_valid,
	input  wire logic                       wk_write,
	input  wire logic                       wk_read,
	input  wire logic                       wk_atomic,
	input  wire logic                       wk_zero_len,
	input  wire logic [63:0]                wk_addr,
	input  wire logic                       wk_root_table_err,
	input  wire logic                       wk_root_present,
	input  wire logic                       wk_root_rsvd,
	input  wire logic                       wk_ctx_table_err,
	input  wire logic                       wk_ctx_present,
	input  wire logic                       wk_ctx_rsvd,
	input  wire logic [2:0]                 wk_addr_width_field,
	input  wire logic [1:0]                 wk_ctx_ttype,
	input  wire logic                       wk_space_root_err,
	input  wire logic                       wk_ttype_block,
	input  wire logic                       wk_pt_err,
	input  wire logic                       wk_pte_read,
	input  wire logic                       wk_pte_write,
	input  wire logic                       wk_pte_rsvd,
	// Classified outcome
	output logic                            fault_valid,
	output logic      [7:0]                 fault_reason,
	output logic                            xlate_ok,
	output logic                            irq
);
	import fre_pkg::*;

	////////////////////////////////////////////////////////////////////

	function automatic logic [31:0] merge_strb(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  strb,
		input logic [31:0] wmask
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r & wmask;
	endfunction

	function automatic logic reg_mapped(input logic [BUS_AB-1:0] a);
		unique case (a)
			OFS_CTRL:  return 1'b1;
			OFS_CAP:   return 1'b1;
			OFS_STAT:  return 1'b1;
			OFS_MASK:  return 1'b1;
			OFS_LAST:  return 1'b1;
			OFS_FA_LO: return 1'b1;
			OFS_FA_HI: return 1'b1;
			OFS_CNT:   return 1'b1;
			default:   return 1'b0;
		endcase
	endfunction

	// Adjusted guest width from the context address-width code
	function automatic logic [6:0] agaw_bits(input logic [2:0] code);
		return 7'(AGAW_BASE + 7'(AGAW_STEP * {4'h0, code}));
	endfunction

	////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic        f_valid;
		logic [7:0]  f_reason;
		logic        ok;
		logic [31:0] ctrl;
		logic [31:0] cap;
		fre_rec_s    rec_in;
		fre_rec_s    last;
		logic [63:0] addr_in;
		logic [63:0] faddr;
		logic [15:0] cnt;
	} fre_top_s;

	fre_top_s q;
	fre_top_s d;

	logic              wr_go;
	logic [BUS_AB-1:0] wr_a;
	logic [31:0]       wr_d;
	logic [3:0]        wr_s;
	logic              rd_go;
	logic [BUS_AB-1:0] rd_a;
	logic [31:0]       rd_d;
	logic [NSTAT-1:0]  ev_set;
	logic [NSTAT-1:0]  status;
	logic [NSTAT-1:0]  mask;
	logic [31:0]       mask_new;
	logic              stat_rd;
	logic              mask_we;

	logic [5:0]  mgw;
	logic [6:0]  xw;
	logic [6:0]  ctx_w;
	logic [4:0]  saw;
	logic [3:0]  stt;
	logic        aw_ok;
	logic        tt_ok;
	logic        addr_over;
	logic        rd_need;
	logic        zlen_skip;
	logic        ctx_bad;
	logic        pte_bad;
	logic        wr_deny;
	logic        rd_deny;
	logic [7:0]  reason;

	////////////////////////////////////////////////////////////////////
	// Classification, combinational on the walker result

	always_comb begin
		mgw = q.cap[CAP_MGW_LSB +: 6];
		saw = q.cap[CAP_SAW_LSB +: 5];
		stt = q.cap[CAP_STT_LSB +: 4];
		ctx_w = agaw_bits(wk_addr_width_field);
		xw = ({1'b0, mgw} < ctx_w) ? {1'b0, mgw} : ctx_w;
		addr_over = (xw < ADDR_BITS) && ((wk_addr >> xw) != 64'h0);
		aw_ok = (wk_addr_width_field < 3'h5) && saw[wk_addr_width_field];
		tt_ok = stt[wk_ctx_ttype];

		// Write-only page, zero-length plain read, capability set
		zlen_skip = q.cap[CAP_ZLEN_BIT] && wk_zero_len && !wk_atomic
			&& wk_pte_write;
		rd_need = (wk_read || wk_atomic) && !zlen_skip;
		// Three programming errors of a present context share code 3
		ctx_bad = !aw_ok || !tt_ok || wk_space_root_err;
		pte_bad = wk_pte_rsvd && (wk_pte_read || wk_pte_write);
		wr_deny = (wk_write || wk_atomic) && !wk_pte_write;
		rd_deny = rd_need && !wk_pte_read;
		// Checks follow the walk: root, context, then page tables
		// Type blocking is judged only once the context is valid
		if (wk_root_table_err) begin
			reason = FR_RT_ERR;
		end else if (!wk_root_present) begin
			reason = FR_ROOT_NP;
		end else if (wk_root_rsvd) begin
			reason = FR_ROOT_RSV;
		end else if (wk_ctx_table_err) begin
			reason = FR_CT_ERR;
		end else if (!wk_ctx_present) begin
			reason = FR_CTX_NP;
		end else if (wk_ctx_rsvd) begin
			reason = FR_CTX_RSV;
		end else if (ctx_bad) begin
			reason = FR_CTX_INV;
		end else if (wk_ttype_block) begin
			reason = FR_TT_BLK;
		end else if (addr_over) begin
			reason = FR_ADDR_OVR;
		end else if (wk_pt_err) begin
			reason = FR_PT_ERR;
		end else if (pte_bad) begin
			reason = FR_PTE_RSV;
		end else if (wr_deny) begin
			reason = FR_WR_DENY;
		end else if (rd_deny) begin
			reason = FR_RD_DENY;
		end else begin
			reason = FR_EMPTY;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register reads

	always_comb begin
		unique case (rd_a)
			OFS_CTRL:  rd_d = q.ctrl;
			OFS_CAP:   rd_d = q.cap;
			OFS_STAT:  rd_d = {{(32-NSTAT){1'b0}}, status};
			OFS_MASK:  rd_d = {{(32-NSTAT){1'b0}}, mask};
			OFS_LAST:  rd_d = {20'h0, q.last};
			OFS_FA_LO: rd_d = q.faddr[31:0];
			OFS_FA_HI: rd_d = q.faddr[63:32];
			OFS_CNT:   rd_d = {16'h0, q.cnt};
			default:   rd_d = 32'h0;
		endcase
	end

	assign stat_rd = rd_go && (rd_a == OFS_STAT);
	assign mask_we = wr_go && (wr_a == OFS_MASK);
	assign mask_new = merge_strb({{(32-NSTAT){1'b0}}, mask}, wr_d, wr_s,
		32'(2**NSTAT - 1));

	////////////////////////////////////////////////////////////////////
	// State update

	always_comb begin
		d = q;
		// Only a non-zero code counts as a fault
		d.f_valid = wk_valid && (reason != FR_EMPTY);
		d.f_reason = wk_valid ? reason : FR_EMPTY;
		d.ok = wk_valid && (reason == FR_EMPTY);
		d.rec_in = '{
			zlen:   wk_zero_len,
			atom:   wk_atomic,
			rd:     wk_read,
			wr:     wk_write,
			reason: reason
		};
		d.addr_in = wk_addr;
		ev_set = '0;
		// Recording trails the output by a cycle; blocking never waits
		if (q.f_valid && q.ctrl[CTRL_EN_BIT]) begin
			d.last = q.rec_in;
			d.faddr = q.addr_in;
			ev_set[ST_FAULT] = 1'b1;
			if (q.cnt != CNT_MAX) begin
				d.cnt = q.cnt + 16'h1;
				ev_set[ST_SAT] = (q.cnt == (CNT_MAX - 16'h1));
			end
		end

		// Read-only offsets answer OKAY on write and keep their value
		if (wr_go && (wr_a == OFS_CTRL)) begin
			d.ctrl = merge_strb(q.ctrl, wr_d, wr_s, CTRL_WMASK);
			// A clear in the same cycle as a count wins
			if (wr_s[0] && wr_d[CTRL_CCLR_BIT]) begin
				d.cnt = 16'h0;
			end
		end

		// A narrower capability applies from the next walk on
		if (wr_go && (wr_a == OFS_CAP)) begin
			d.cap = merge_strb(q.cap, wr_d, wr_s, CAP_WMASK);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.cap <= CAP_RST;
		end else begin
			q <= d;
		end
	end

	assign fault_valid  = q.f_valid;
	assign fault_reason = q.f_reason;
	assign xlate_ok     = q.ok;

	////////////////////////////////////////////////////////////////////

	fre_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.awaddr  (s_axi_awaddr),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.bresp   (s_axi_bresp),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.araddr  (s_axi_araddr),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.wr_go   (wr_go),
		.wr_a    (wr_a),
		.wr_d    (wr_d),
		.wr_s    (wr_s),
		.wr_err  (!reg_mapped(wr_a)),
		.rd_go   (rd_go),
		.rd_a    (rd_a),
		.rd_d    (rd_d),
		.rd_err  (!reg_mapped(rd_a))
	);

	fre_irq #(
		.W (NSTAT)
	) u_irq (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ev_set  (ev_set),
		.stat_rd (stat_rd),
		.mask_we (mask_we),
		.mask_d  (mask_new[NSTAT-1:0]),
		.status  (status),
		.mask    (mask),
		.irq     (irq)
	);

endmodule // fre_fault_encoder
`default_nettype wire

// >>> fre_fault_encoder_assertions.sv
// Checker for the fault reason encoder: walk priority and bus timing.
// Assumes it is bound to the encoder top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fre_fault_encoder_assertions (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       wk_valid,
	input wire logic       wk_root_table_err,
	input wire logic       wk_root_present,
	input wire logic       wk_root_rsvd,
	input wire logic       wk_ctx_table_err,
	input wire logic       wk_ctx_present,
	input wire logic       wk_ctx_rsvd,
	input wire logic       fault_valid,
	input wire logic [7:0] fault_reason,
	input wire logic       xlate_ok,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid
);
	import fre_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	sequence root_ok_s;
		wk_valid && !wk_root_table_err && wk_root_present && !wk_root_rsvd;
	endsequence
	sequence ctx_tbl_ok_s;
		root_ok_s ##0 !wk_ctx_table_err;
	endsequence
	property code_p(logic c, logic [7:0] v);
		c |=> fault_valid && fault_reason == v;
	endproperty
	one_answer_a:
		assert property (wk_valid |=> fault_valid != xlate_ok)
		else $error("walk result not answered exactly once");
	quiet_idle_a:
		assert property (!wk_valid |=> !fault_valid && fault_reason == 8'h00)
		else $error("code shown without a request");
	code_range_a:
		assert property (fault_valid |-> fault_reason inside {[8'h01:8'h0d]})
		else $error("unassigned fault code");
	rt_err_a:
		assert property (code_p(wk_valid && wk_root_table_err, FR_RT_ERR))
		else $error("root table error code wrong");
	root_np_a:
		assert property (code_p(wk_valid && !wk_root_table_err
			&& !wk_root_present, FR_ROOT_NP))
		else $error("root not present code wrong");
	root_rsv_a:
		assert property (code_p(wk_valid && !wk_root_table_err
			&& wk_root_present && wk_root_rsvd, FR_ROOT_RSV))
		else $error("root reserved code wrong");
	ct_err_a:
		assert property (root_ok_s ##0 wk_ctx_table_err
			|=> fault_valid && fault_reason == FR_CT_ERR)
		else $error("context table error code wrong");
	ctx_np_a:
		assert property (ctx_tbl_ok_s ##0 !wk_ctx_present
			|=> fault_valid && fault_reason == FR_CTX_NP)
		else $error("context not present code wrong");
	ctx_rsv_a:
		assert property (ctx_tbl_ok_s ##0 (wk_ctx_present && wk_ctx_rsvd)
			|=> fault_valid && fault_reason == FR_CTX_RSV)
		else $error("context reserved code wrong");
	read_lat_a:
		assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
		else $error("read answer late");
endmodule // fre_fault_encoder_assertions
bind fre_fault_encoder fre_fault_encoder_assertions
	u_fre_fault_encoder_assertions (.aclk, .aresetn, .wk_valid,
	.wk_root_table_err, .wk_root_present, .wk_root_rsvd, .wk_ctx_table_err,
	.wk_ctx_present, .wk_ctx_rsvd, .fault_valid, .fault_reason, .xlate_ok,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// >>> fre_irq.sv
// Sticky event status with mask and one level interrupt.
// Assumes events and the read strobe come from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
module fre_irq #(
	parameter int W = 2
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] ev_set,
	input  wire logic         stat_rd,
	input  wire logic         mask_we,
	input  wire logic [W-1:0] mask_d,
	output logic      [W-1:0] status,
	output logic      [W-1:0] mask,
	output logic              irq
);
	import fre_pkg::*;

	typedef struct packed {
		logic [W-1:0] st;
		logic [W-1:0] mk;
		logic         irq;
	} fre_irq_s;

	fre_irq_s q;
	fre_irq_s d;

	always_comb begin
		d = q;
		if (stat_rd) begin
			d.st = '0;
		end
		// An event in the clearing cycle survives the read
		d.st = d.st | ev_set;
		if (mask_we) begin
			d.mk = mask_d;
		end
		d.irq = |(d.st & d.mk);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign status = q.st;
	assign mask   = q.mk;
	assign irq    = q.irq;
endmodule // fre_irq
`default_nettype wire

// >>> fre_pkg.sv
// Constants shared by the DMA remapping fault reason encoder.
// Assumes a 32-bit AXI4-Lite register port with byte addresses.
package fre_pkg;

	localparam int BUS_AB = 8;

	// Fault reason codes, eight bits wide
	localparam logic [7:0] FR_EMPTY    = 8'h00;
	localparam logic [7:0] FR_ROOT_NP  = 8'h01;
	localparam logic [7:0] FR_CTX_NP   = 8'h02;
	localparam logic [7:0] FR_CTX_INV  = 8'h03;
	localparam logic [7:0] FR_ADDR_OVR = 8'h04;
	localparam logic [7:0] FR_WR_DENY  = 8'h05;
	localparam logic [7:0] FR_RD_DENY  = 8'h06;
	localparam logic [7:0] FR_PT_ERR   = 8'h07;
	localparam logic [7:0] FR_RT_ERR   = 8'h08;
	localparam logic [7:0] FR_CT_ERR   = 8'h09;
	localparam logic [7:0] FR_ROOT_RSV = 8'h0a;
	localparam logic [7:0] FR_CTX_RSV  = 8'h0b;
	localparam logic [7:0] FR_PTE_RSV  = 8'h0c;
	localparam logic [7:0] FR_TT_BLK   = 8'h0d;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_CAP   = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_MASK  = 8'h0c;
	localparam logic [7:0] OFS_LAST  = 8'h10;
	localparam logic [7:0] OFS_FA_LO = 8'h14;
	localparam logic [7:0] OFS_FA_HI = 8'h18;
	localparam logic [7:0] OFS_CNT   = 8'h1c;

	// Field positions and reset values
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_CCLR_BIT = 1;
	localparam int CAP_MGW_LSB   = 0;
	localparam int CAP_ZLEN_BIT  = 6;
	localparam int CAP_SAW_LSB   = 8;
	localparam int CAP_STT_LSB   = 16;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0001;
	localparam logic [31:0] CAP_RST    = 32'h0005_0430;
	localparam logic [31:0] CAP_WMASK  = 32'h000f_1f7f;

	localparam int NSTAT    = 2;
	localparam int ST_FAULT = 0;
	localparam int ST_SAT   = 1;

	localparam logic [6:0]  AGAW_BASE = 7'h1e;
	localparam logic [6:0]  AGAW_STEP = 7'h09;
	localparam logic [6:0]  ADDR_BITS = 7'h40;
	localparam logic [15:0] CNT_MAX   = 16'hffff;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       zlen;
		logic       atom;
		logic       rd;
		logic       wr;
		logic [7:0] reason;
	} fre_rec_s;

endpackage

// >>> fre_walk_model.sv
// Stand-in for the translation walker: one result per send call.
// Assumes calls come from one process on aclk.
`timescale 1ns/1ps
`default_nettype none
module fre_walk_model (
	input  wire logic        aclk,
	output logic             wk_valid,
	output logic      [20:0] wk_bits,
	output logic      [63:0] wk_addr
);
	initial begin
		wk_valid = 1'b0;
		wk_bits = 21'h0;
		wk_addr = 64'h0;
	end
	task automatic send(input logic [20:0] b, input logic [63:0] a);
		@(posedge aclk);
		wk_valid <= 1'b1;
		wk_bits <= b;
		wk_addr <= a;
	endtask
	// Lines flip when released, so a stale result never looks valid
	task automatic stop();
		@(posedge aclk);
		wk_valid <= 1'b0;
		wk_bits <= ~wk_bits;
		wk_addr <= ~wk_addr;
	endtask
endmodule // fre_walk_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the DMA remapping fault reason encoder.
// Assumes the package, walker model and bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fre_pkg::*;
	typedef struct packed {
		logic       wr, rd, at, zl, rte, rp, rrs, cte, cp, crs;
		logic [2:0] aw;
		logic [1:0] tt;
		logic       sre, tbk, pte, pr, pw, prs;
	} fre_req_s;
	localparam logic [20:0] RD_WO = 21'h0a9202; // zero-length read, W only
	logic        aclk, aresetn, irq, fault_valid, xlate_ok, wk_valid, pend;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, en_q;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, fault_reason, pend_exp;
	logic [31:0] s_axi_wdata, s_axi_rdata, cap_q;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb;
	logic [63:0] wk_addr;
	logic [13:0] seen;
	fre_req_s    wk;
	int          num_errors, checks_done, n_flt;
	fre_fault_encoder u_fre_fault_encoder (.aclk, .aresetn, .s_axi_awvalid,
		.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .wk_valid,
		.wk_write(wk.wr), .wk_read(wk.rd), .wk_atomic(wk.at),
		.wk_zero_len(wk.zl), .wk_addr, .wk_root_table_err(wk.rte),
		.wk_root_present(wk.rp), .wk_root_rsvd(wk.rrs),
		.wk_ctx_table_err(wk.cte), .wk_ctx_present(wk.cp),
		.wk_ctx_rsvd(wk.crs), .wk_addr_width_field(wk.aw),
		.wk_ctx_ttype(wk.tt), .wk_space_root_err(wk.sre),
		.wk_ttype_block(wk.tbk), .wk_pt_err(wk.pte), .wk_pte_read(wk.pr),
		.wk_pte_write(wk.pw), .wk_pte_rsvd(wk.prs), .fault_valid,
		.fault_reason, .xlate_ok, .irq);
	fre_walk_model u_fre_walk_model (.aclk, .wk_valid, .wk_bits(wk), .wk_addr);
	always #12.5 aclk = ~aclk;
	////////////////////////////////////////
	function automatic logic [7:0] exp_reason(fre_req_s r, logic [63:0] a,
			logic [31:0] c);
		int x;
		x = 30 + 9 * r.aw;
		if (c[5:0] < x) x = c[5:0];
		if (r.rte) return FR_RT_ERR;
		if (!r.rp) return FR_ROOT_NP;
		if (r.rrs) return FR_ROOT_RSV;
		if (r.cte) return FR_CT_ERR;
		if (!r.cp) return FR_CTX_NP;
		if (r.crs) return FR_CTX_RSV;
		if (r.aw > 3'h4 || !c[8 + r.aw] || !c[16 + r.tt] || r.sre)
			return FR_CTX_INV;
		if (r.tbk) return FR_TT_BLK;
		if (x < 64 && (a >> x) != 64'h0) return FR_ADDR_OVR;
		if (r.pte) return FR_PT_ERR;
		if (r.prs && (r.pr || r.pw)) return FR_PTE_RSV;
		if ((r.wr || r.at) && !r.pw) return FR_WR_DENY;
		if ((r.rd || r.at) && !r.pr && !(c[6] && r.zl && !r.at && r.pw))
			return FR_RD_DENY;
		return FR_EMPTY;
	endfunction
	task automatic chk_word(logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_fault(logic [7:0] e);
		checks_done++;
		if (fault_valid !== (e != 0) || xlate_ok !== (e == 0)
				|| fault_reason !== e) begin
			num_errors++;
			$display("[FAIL] %0t code %h expected %h", $time, fault_reason, e);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk_word(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic axi_rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk_word(s_axi_rdata, ed);
		chk_word(32'(s_axi_rresp), 32'(er));
	endtask
	// Error flags are sparse, each set one walk in eight; other fields stay random
	task automatic walks(int n);
		fre_req_s r;
		logic [31:0] e;
		for (int i = 0; i < n; i++) begin
			r = 21'($urandom);
			e = $urandom & $urandom & $urandom;
			r.rte = e[0];
			r.rp = !e[1];
			r.rrs = e[2];
			r.cte = e[3];
			r.cp = !e[4];
			r.crs = e[5];
			r.sre = e[6];
			r.pte = e[7];
			u_fre_walk_model.send(r, {$urandom, $urandom} >> ($urandom % 64));
			if (e[8]) u_fre_walk_model.stop();
		end
		u_fre_walk_model.send(RD_WO, 64'h0);
		u_fre_walk_model.send(RD_WO | 21'h4, 64'h0000_ffff_ffff_ffff);
		u_fre_walk_model.send(RD_WO | 21'h4, 64'h0001_0000_0000_0000);
		u_fre_walk_model.send('1, '1);
		u_fre_walk_model.stop();
		repeat (3) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		if (pend)
			chk_fault(pend_exp);
		pend = aresetn && wk_valid;
		pend_exp = exp_reason(wk, wk_addr, cap_q);
		if (pend) seen[pend_exp] = 1'b1;
		if (pend && en_q && pend_exp != FR_EMPTY) n_flt++;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run();
	end
	////////////////////////////////////////
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, pend, seen, n_flt} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{num_errors, checks_done} = '0;
		cap_q = CAP_RST;
		en_q = 1'b1;
		void'($urandom(57885));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
		axi_rd(OFS_CAP, CAP_RST, RESP_OKAY);
		axi_rd(OFS_CNT, 32'h0, RESP_OKAY);
		axi_rd(8'h20, 32'h0, RESP_SLVERR);
		axi_wr(8'h24, 32'hffff_ffff, RESP_SLVERR);
		axi_wr(OFS_STAT, 32'hffff_ffff, RESP_OKAY);
		axi_rd(OFS_STAT, 32'h0, RESP_OKAY);
		$display("test registers done");
		walks(300);
		axi_rd(OFS_LAST, 32'h0000_0f08, RESP_OKAY);
		axi_rd(OFS_FA_HI, 32'hffff_ffff, RESP_OKAY);
		$display("test walks at reset capability done");
		axi_wr(OFS_MASK, 32'h3, RESP_OKAY);
		axi_rd(OFS_MASK, 32'h3, RESP_OKAY);
		chk_word({31'h0, irq}, 32'h1);
		axi_rd(OFS_STAT, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk_word({31'h0, irq}, 32'h0);
		axi_rd(OFS_CNT, 32'(n_flt), RESP_OKAY);
		axi_wr(OFS_CTRL, 32'h2, RESP_OKAY);
		n_flt = 0;
		en_q = 1'b0;
		u_fre_walk_model.send('1, '1);
		u_fre_walk_model.stop();
		repeat (3) @(posedge aclk);
		axi_rd(OFS_CNT, 32'h0, RESP_OKAY);
		chk_word({31'h0, irq}, 32'h0);
		axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
		en_q = 1'b1;
		$display("test interrupt and counter done");
		s_axi_wstrb <= 4'h2;
		axi_wr(OFS_CAP, 32'hffff_ffff, RESP_OKAY);
		axi_rd(OFS_CAP, (CAP_RST & 32'hffff_00ff) | (CAP_WMASK & 32'h0000_ff00),
			RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		axi_wr(OFS_CAP, 32'hffff_ffff, RESP_OKAY);
		cap_q = CAP_WMASK;
		axi_rd(OFS_CAP, CAP_WMASK, RESP_OKAY);
		walks(300);
		chk_word(32'(seen), 32'h0000_3fff);
		$display("test walks at full capability done");
		complete_run();
	end
endmodule // tb
`default_nettype wire
